// [rkpb_pkg.sv]
/*
  Package for the kernel program RAM base block: register offsets, field
  positions, reset values, the bus slave state enum and the carrier structs.
  Assumes a 32-bit Avalon-MM register bus with word addressing in bytes.
*/
package rkpb_pkg;

  // Byte offsets of the registers on the Avalon-MM bus.
  localparam logic [3:0] RKPB_OFF_BASE = 4'h0;
  localparam logic [3:0] RKPB_OFF_SIZE = 4'h4;
  localparam logic [3:0] RKPB_OFF_STAT = 4'h8;

  // Field layout of the base register.
  localparam int RKPB_BASE_LSB = 10;
  localparam int RKPB_BASE_MSB = 15;
  localparam int RKPB_BASE_W = RKPB_BASE_MSB - RKPB_BASE_LSB + 1;

  // Field layout of the status register.
  localparam int RKPB_STAT_REGION = 0;
  localparam int RKPB_STAT_LEGAL = 1;

  // Reset values.
  localparam logic [5:0] RKPB_BASE_RST = 6'h00;
  localparam logic [5:0] RKPB_SIZE_RST = 6'h00;

  // Answer to an unmapped read.
  localparam logic [31:0] RKPB_UNMAPPED = 32'h0000_0000;

  // Bus slave states.
  typedef enum logic [0:0] {
    RKPB_IDLE,
    RKPB_DONE
  } rkpb_bus_e;

  // One Avalon-MM request as seen by the slave.
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } rkpb_req_s;

  // State of the top module outside the field register u_base.
  typedef struct packed {
    rkpb_bus_e bus;
    logic [5:0] base;
    logic [5:0] size;
    logic [31:0] rdata;
  } rkpb_state_s;

endpackage

// [rkpb_field.sv]
/*
  Small register for one six-bit granule field with byte-lane write.
  Assumes the caller presents a single-cycle write strobe and full word data.
*/
`timescale 1ns/1ns
`default_nettype none
module rkpb_field
  import rkpb_pkg::*;
#(
  parameter logic [5:0] RESET_VALUE = RKPB_BASE_RST
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Write side.
  input wire logic wr,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  // Stored field.
  output logic [5:0] q
);

  logic [5:0] q_reg; // Held field value.
  logic [5:0] q_next; // Next value.

  // Only bits 15:10 take write data; all other lanes are dropped here.
  always_comb begin
    q_next = q_reg;
    if (wr && be[1]) begin
      q_next = wdata[RKPB_BASE_MSB:RKPB_BASE_LSB];
    end
  end

  // Reset forces the field to its constant reset value.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_reg <= RESET_VALUE;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule
`default_nettype wire

// [rkpb_top.sv]
/*
  Kernel program RAM base register with an Avalon-MM slave. It splits data
  RAM into a kernel data part below the base and a kernel program part above.
  Assumes one clock, an asynchronous active-high reset and an Avalon master
  that holds its request while waitrequest is high. Software is trusted to
  keep the base at or below the size setting; the block only flags a breach
  and never refuses the write, so the partition follows whatever is stored.
*/
`timescale 1ns/1ns
`default_nettype none
module rkpb_top
  import rkpb_pkg::*;
#(
  parameter int ADDR_W = 16 // Width of a RAM byte address.
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // RAM address in and partition outputs.
  input wire logic [ADDR_W-1:0] ram_addr,
  output logic prog_region_en,
  output logic [ADDR_W-1:0] prog_start,
  output logic ram_addr_is_prog,
  output logic base_too_high
);

  // The base field covers address bits 15:10, so narrower RAM is refused.
  // The check runs while the block is built, not at run time, so a bad
  // parameter can never reach a working netlist.
  if (ADDR_W < RKPB_BASE_MSB + 1) begin
    $error("ADDR_W too small for the base field");
  end

  rkpb_req_s req; // Bundled bus request.
  rkpb_state_s s_reg; // Registered state.
  rkpb_state_s s_next; // Next state.
  logic [5:0] base_q; // Base field from the field register.
  logic base_wr; // One-cycle write strobe to the base field.
  logic size_wr; // One-cycle write strobe to the size setting.

  assign req = '{avs_address, avs_read, avs_write, avs_byteenable, avs_writedata};

  // Place a granule field at bits 15:10 of a 32-bit word, zero elsewhere.
  function automatic logic [31:0] rkpb_word(input logic [5:0] f);
    rkpb_word = {16'h0000, f, 10'h000};
  endfunction

  // The field register; write lanes other than byte 1 are ignored.
  assign base_wr = (s_reg.bus == RKPB_IDLE) && req.write &&
                   (req.address == RKPB_OFF_BASE);
  rkpb_field #(.RESET_VALUE(RKPB_BASE_RST)) u_base (
    .clk(clk),
    .rst(rst),
    .wr(base_wr),
    .be(req.byteenable),
    .wdata(req.writedata),
    .q(base_q)
  );

  assign size_wr = (s_reg.bus == RKPB_IDLE) && req.write &&
                   (req.address == RKPB_OFF_SIZE);

  // Bus slave: each access waits one cycle, then completes with read data
  // already registered. The fixed latency keeps the master logic simple.
  always_comb begin
    s_next = s_reg;
    s_next.base = base_q;
    case (s_reg.bus)
      RKPB_IDLE: begin
        if (req.read || req.write) begin
          s_next.bus = RKPB_DONE;
          if (size_wr && req.byteenable[1]) begin
            s_next.size = req.writedata[RKPB_BASE_MSB:RKPB_BASE_LSB];
          end
          // Read data for an unmapped or write access is zero.
          s_next.rdata = RKPB_UNMAPPED;
          if (req.read) begin
            case (req.address)
              RKPB_OFF_BASE: s_next.rdata = rkpb_word(base_q);
              RKPB_OFF_SIZE: s_next.rdata = rkpb_word(s_reg.size);
              RKPB_OFF_STAT: begin
                s_next.rdata = 32'h0000_0000;
                s_next.rdata[RKPB_STAT_REGION] = prog_region_en;
                s_next.rdata[RKPB_STAT_LEGAL] = ~base_too_high;
              end
              default: s_next.rdata = RKPB_UNMAPPED;
            endcase
          end
        end
      end
      RKPB_DONE: begin
        // Master drops or renews its request after this edge.
        s_next.bus = RKPB_IDLE;
      end
      default: s_next.bus = RKPB_IDLE;
    endcase
  end

  // State register; reset is constants only.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{RKPB_IDLE, RKPB_BASE_RST, RKPB_SIZE_RST, 32'h0000_0000};
    end else begin
      s_reg <= s_next;
    end
  end

  // Waitrequest stays high until the registered answer is in place.
  assign avs_waitrequest = (avs_read || avs_write) && (s_reg.bus != RKPB_DONE);
  assign avs_readdata = s_reg.rdata;

  // Partition outputs: a zero base means no program region at all.
  assign prog_region_en = (s_reg.base != 6'h00);
  always_comb begin
    prog_start = '0;
    prog_start[RKPB_BASE_MSB:RKPB_BASE_LSB] = s_reg.base;
  end
  assign ram_addr_is_prog = prog_region_en && (ram_addr >= prog_start);

  // Software must keep the base within the size; flag it if it does not.
  assign base_too_high = (s_reg.base > s_reg.size);

  // Assertions. Apart from the base_wr strobe in a_base_write and a_base_hold, each one looks at registered state or at the ports, so a
  // slip in the decode above shows up as a firing here rather than as a
  // silent wrong value at the bus.

  // Read data never carries anything in the unimplemented upper half.
  a_upper_zero: assert property (@(posedge clk) disable iff (rst)
    (s_reg.rdata[31:16] == 16'h0000))
    else $error("upper bits not zero");

  // A completed base read shows the fixed low bits as zero; the status word
  // uses its own low bits, so only base reads are held to this.
  a_low_zero: assert property (@(posedge clk) disable iff (rst)
    avs_read && !avs_waitrequest && (avs_address == RKPB_OFF_BASE) |->
    (avs_readdata[RKPB_BASE_LSB-1:0] == 10'h000))
    else $error("low bits not zero");

  // A start boundary always falls on a 1 KB granule.
  a_start_align: assert property (@(posedge clk) disable iff (rst)
    (prog_start[RKPB_BASE_LSB-1:0] == 10'h000))
    else $error("start not on a granule");

  // A write with lane 1 on reaches the registered copy two edges later.
  a_base_write: assert property (@(posedge clk) disable iff (rst)
    base_wr && req.byteenable[1] |=> ##1
    (s_reg.base == $past(req.writedata[RKPB_BASE_MSB:RKPB_BASE_LSB], 2)))
    else $error("base write lost");

  // Without a write strobe the field register keeps its value.
  a_base_hold: assert property (@(posedge clk) disable iff (rst)
    !base_wr |=> (base_q == $past(base_q)))
    else $error("base changed without write");

  // A zero base leaves no program region and claims no address.
  a_zero_region: assert property (@(posedge clk) disable iff (rst)
    (s_reg.base == 6'h00) |-> !ram_addr_is_prog && !prog_region_en)
    else $error("region with zero base");

  // Every address at or above the start granule belongs to the program part.
  a_prog_map: assert property (@(posedge clk) disable iff (rst)
    prog_region_en && (ram_addr[RKPB_BASE_MSB:RKPB_BASE_LSB] >= s_reg.base) |->
    ram_addr_is_prog)
    else $error("program address missed");

  // Every address below the start granule stays with kernel data.
  a_below_start: assert property (@(posedge clk) disable iff (rst)
    prog_region_en && ((ram_addr >> RKPB_BASE_LSB) < s_reg.base) |-> !ram_addr_is_prog)
    else $error("data address claimed");

  // Right after reset the base is clear in both copies.
  a_reset_clear: assert property (@(posedge clk)
    $fell(rst) |-> (s_reg.base == 6'h00) && (base_q == 6'h00))
    else $error("reset left base set");

  // Right after reset the partition outputs show no program region.
  a_rst_outputs: assert property (@(posedge clk)
    $fell(rst) |-> !prog_region_en && (prog_start == '0))
    else $error("reset left region open");

  // A base within the size setting is never flagged.
  a_size_flag: assert property (@(posedge clk) disable iff (rst)
    (s_reg.base <= s_reg.size) |-> !base_too_high)
    else $error("legal base flagged");

  // A fresh base read completes one cycle later with the stored field.
  a_bus_answer: assert property (@(posedge clk) disable iff (rst)
    $rose(avs_read) && (avs_address == RKPB_OFF_BASE) |-> ##1
    (!avs_waitrequest && avs_readdata == rkpb_word(base_q)))
    else $error("read answer wrong");

endmodule
`default_nettype wire

// [rkpb_top_test.sv]
/*
  Self-checking bench for the kernel program RAM base block.
  Assumes rkpb_pkg and rkpb_top are compiled first and one 20 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module rkpb_top_test
  import rkpb_pkg::*;
;
  // Stimulus registers, all given a value at time zero.
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [3:0] be = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [15:0] ram_addr = 16'h0;
  // Observed outputs.
  logic [31:0] readdata;
  logic [31:0] rdata_s;
  logic waitreq;
  logic region_en;
  logic is_prog;
  logic too_high;
  logic [15:0] start;
  int err_count = 0;
  int num_checks = 0;
  // Bases that hit the lowest non-zero value and the top value of the six-bit field.
  logic [5:0] bases [4] = '{6'h01, 6'h08, 6'h20, 6'h3F};

  rkpb_top #(.ADDR_W(16)) dut_u (.clk(clk), .rst(rst), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_byteenable(be), .avs_writedata(wdata),
    .avs_readdata(readdata), .avs_waitrequest(waitreq), .ram_addr(ram_addr),
    .prog_region_en(region_en), .prog_start(start), .ram_addr_is_prog(is_prog),
    .base_too_high(too_high));

  // Free-running clock of 50 ns.
  initial begin
    forever #25 clk = ~clk;
  end

  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus cycle. Waitrequest is looked at on the rising edge, before the
  // slave's registers move, so the value seen is the one the slave showed.
  // The request stands until that edge; a hang is ended by the watchdog.
  task automatic access(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] lanes);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    be <= lanes;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    rdata_s = readdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wrt(input logic [3:0] a, input logic [31:0] d);
    access(1'b1, a, d, 4'hF);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    access(1'b0, a, 32'h0, 4'hF);
    check(rdata_s, exp);
  endtask

  // Moves the classified address and lets it settle.
  task automatic probe(input logic [15:0] a);
    ram_addr <= a;
    @(negedge clk);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence of tests.
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdchk(RKPB_OFF_BASE, 32'h0);
    // Outputs are read between edges, where they have settled.
    @(negedge clk);
    check({31'h0, region_en}, 32'h0);
    $display("reset test done");
    // Open the size setting fully so that every base below stays legal.
    wrt(RKPB_OFF_SIZE, 32'h0000_FC00);
    rdchk(RKPB_OFF_SIZE, 32'h0000_FC00);
    // Junk in the fixed bits must not stick.
    foreach (bases[i]) begin
      wrt(RKPB_OFF_BASE, 32'hFFFF_03FF | {16'h0, bases[i], 10'h0});
      rdchk(RKPB_OFF_BASE, {16'h0, bases[i], 10'h0});
      probe({bases[i], 10'h0} - 16'h1);
      check({31'h0, is_prog}, 32'h0);
      check({16'h0, start}, {16'h0, bases[i], 10'h0});
      check({31'h0, too_high}, 32'h0);
      probe({bases[i], 10'h0});
      check({31'h0, is_prog}, 32'h1);
    end
    $display("base test done");
    access(1'b1, RKPB_OFF_BASE, 32'h0, 4'hD);
    wrt(4'hC, 32'h0);
    rdchk(RKPB_OFF_BASE, 32'h0000_FC00);
    rdchk(4'hC, 32'h0);
    wrt(RKPB_OFF_BASE, 32'h0);
    probe(16'hFFFF);
    check({30'h0, region_en, is_prog}, 32'h0);
    $display("lane test done");
    wrt(RKPB_OFF_SIZE, 32'h0000_4000);
    rdchk(RKPB_OFF_SIZE, 32'h0000_4000);
    // Deliberately above the size, to see the breach flagged.
    wrt(RKPB_OFF_BASE, 32'h0000_8000);
    @(negedge clk);
    check({31'h0, too_high}, 32'h1);
    rdchk(RKPB_OFF_STAT, 32'h1);
    wrt(RKPB_OFF_BASE, 32'h0000_4000);
    rdchk(RKPB_OFF_STAT, 32'h3);
    $display("size test done");
    rst <= 1'b1;
    @(negedge clk);
    check({15'h0, region_en, start}, 32'h0);
    // Release on a rising edge, as every bus input is driven.
    @(posedge clk);
    rst <= 1'b0;
    rdchk(RKPB_OFF_BASE, 32'h0);
    rdchk(RKPB_OFF_SIZE, 32'h0);
    $display("second reset test done");
    print_verdict();
  end

  // Watchdog; the tests need well under 300 cycles.
  initial begin
    #(50 * 2000);
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
